// ===== dv/dwt_far_side.sv
/*
 Far-side model: drivers for both external count pins and a gated
 sub-oscillator. Assumes clk is the system clock of the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module dwt_far_side
#(
	parameter int HALF = 2
)
(
	// Clock.
	input  wire logic clk,
	// Requested pin levels and oscillator gate.
	input  wire logic want_a,
	input  wire logic want_b,
	input  wire logic sub_en,
	// Driven lines.
	output logic      pin_a,
	output logic      pin_b,
	output logic      sub_osc
);
	int cnt;

	// Pins only ever change after a clock edge, like a port input.
	always @(posedge clk)
	begin
		pin_a <= want_a;
		pin_b <= want_b;
	end

	// The oscillator stands low while gated off.
	always @(posedge clk)
	begin
		cnt <= (cnt + 1) % HALF;
		if (!sub_en)
			sub_osc <= 1'b0;
		else if (cnt == 0)
			sub_osc <= ~sub_osc;
	end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
/*
 Self-checking bench for the timer unit: byte register port tasks,
 pin stimulus through the far-side model, timing checks by counting.
 Assumes the register map and the one-cycle read latency of the unit.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
	import dwt_pkg::*;
	logic        clk, nrst, wr_i, rd_i, want_a, want_b, sub_en;
	logic [7:0]  addr_i, wdata_i, rdata_q, irq_req_q, d;
	logic [15:0] v, c;
	wire logic   pin_a_o, pin_a_oe, far_a, far_b, sub_osc, rt0, rt1;
	wire logic   pin_a;
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          n, k;
	logic [39:0] probe_adr = {DWT_ADR_MODE_A, DWT_ADR_MODE_B,
		DWT_ADR_MODE_8, DWT_ADR_IRQ, 8'h30};

	assign pin_a = pin_a_oe ? pin_a_o : far_a;

	dwt_timer_unit i_dwt_timer_unit (.clk(clk), .nrst(nrst),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_q(rdata_q), .ext_count_pin_a_i(pin_a),
		.ext_count_pin_a_o(pin_a_o), .ext_count_pin_a_oe(pin_a_oe),
		.ext_count_pin_b_i(far_b), .sub_osc_in(sub_osc),
		.rt_out_pin0(rt0), .rt_out_pin1(rt1), .irq_req_q(irq_req_q));
	dwt_far_side i_dwt_far_side (.clk(clk), .want_a(want_a),
		.want_b(want_b), .sub_en(sub_en), .pin_a(far_a), .pin_b(far_b),
		.sub_osc(sub_osc));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic close_out;
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cyc(input int m);
		repeat (m) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		addr_i <= a;
		wdata_i <= x;
		wr_i <= 1'b1;
		@(posedge clk);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] x);
		@(posedge clk);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk);
		rd_i <= 1'b0;
		#1 x = rdata_q;
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] x);
		wr(a, x[7:0]);
		wr(a + 8'h01, x[15:8]);
	endtask

	task automatic rd16(input logic [7:0] a, output logic [15:0] x);
		logic [7:0] hi, lo;
		rd(a + 8'h01, hi);
		rd(a, lo);
		x = {hi, lo};
	endtask

	task automatic clr;
		wr(DWT_ADR_IRQ, 8'h00);
	endtask

	task automatic set(input int p, input logic x);
		if (p == 1)
			want_b <= x;
		else
			want_a <= x;
	endtask

	task automatic pulse(input int p, input int m);
		repeat (m)
		begin
			set(p, 1'b1);
			cyc(4);
			set(p, 1'b0);
			cyc(4);
		end
	endtask

	function automatic logic cur(input int s);
		return (s == 8) ? pin_a_o : irq_req_q[s];
	endfunction

	// Counts cycles until the selected signal changes, up to a limit.
	// The start value is taken after the edge has settled; a limit that
	// runs out counts as a mismatch.
	task automatic wait_chg(input int s, input int lim, output int m);
		logic v0;
		#1 v0 = cur(s);
		m = 0;
		while (cur(s) === v0 && m < lim)
		begin
			@(posedge clk);
			#1 m++;
		end
		if (cur(s) === v0)
			n_mismatch++;
	endtask

	initial
	begin
		#(25 * 40000);
		n_mismatch++;
		close_out;
	end

	initial
	begin
		nrst = 1'b0;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		want_a = 1'b0;
		want_b = 1'b0;
		sub_en = 1'b0;
		void'($urandom(32'he02e));
		cyc(12);
		nrst <= 1'b1;
		cyc(3);
		for (int i = 0; i < 5; i++)
		begin
			rd(probe_adr[8 * i +: 8], d);
			`CHK(d, 8'h00)
		end
		rd16(DWT_ADR_TA_LO, c);
		`CHK(c[15:8], 8'hff)
		// Latch-only write must leave the stopped counter alone.
		wr(DWT_ADR_MODE_A, 8'h80);
		wr16(DWT_ADR_TA_LO, 16'h0001);
		wr(DWT_ADR_MODE_A, 8'h84);
		wr16(DWT_ADR_TA_LO, 16'h0003);
		rd16(DWT_ADR_TA_LO, c);
		`CHK(c, 16'h0001)
		wr(DWT_ADR_MODE_A, 8'h05);
		cyc(2);
		`CHK(pin_a_oe, 1'b1)
		wait_chg(8, 200, n);
		wait_chg(8, 200, n);
		`CHK(n, 64)
		wait_chg(8, 200, n);
		`CHK(n, 64)
		// Enabling the real time port must drive its data to the pins at once.
		wr(DWT_ADR_MODE_A, 8'h2d);
		cyc(2);
		`CHK({rt1, rt0}, 2'b10)
		clr;
		wait_chg(0, 100, n);
		clr;
		wr(DWT_ADR_MODE_A, 8'h1d);
		cyc(2);
		`CHK({rt1, rt0}, 2'b10)
		wait_chg(0, 100, n);
		cyc(2);
		`CHK({rt1, rt0}, 2'b01)
		for (int e = 0; e < 2; e++)
		begin
			wr(DWT_ADR_MODE_A, {1'b1, e[0], 6'h00});
			set(0, e == 0);
			cyc(8);
			clr;
			set(0, e != 0);
			cyc(8);
			`CHK(irq_req_q[5], 1'b0)
			set(0, e == 0);
			cyc(8);
			`CHK(irq_req_q[5], 1'b1)
		end
		for (int p = 0; p < 2; p++)
		begin
			k = $urandom_range(1, 5);
			v = 16'($urandom_range(16'h0010, 16'hfff0));
			wr(p ? DWT_ADR_MODE_B : DWT_ADR_MODE_A, 8'h02);
			set(p, 1'b0);
			cyc(8);
			wr16(p ? DWT_ADR_TB_LO : DWT_ADR_TA_LO, v);
			pulse(p, k);
			cyc(6);
			rd16(p ? DWT_ADR_TB_LO : DWT_ADR_TA_LO, c);
			`CHK(c, v - 16'(k))
		end
		wr(DWT_ADR_MODE_A, 8'h03);
		wr16(DWT_ADR_TA_LO, 16'h0100);
		cyc(100);
		rd16(DWT_ADR_TA_LO, c);
		`CHK(c, 16'h0100)
		wr(DWT_ADR_MODE_A, 8'h43);
		cyc(100);
		rd16(DWT_ADR_TA_LO, c);
		`CHK(c < 16'h0100, 1'b1)
		wr(DWT_ADR_MODE_B, 8'h01);
		wr16(DWT_ADR_TB_LO, 16'h1234);
		cyc(200);
		clr;
		set(1, 1'b1);
		cyc(6);
		`CHK(irq_req_q[6], 1'b1)
		rd16(DWT_ADR_TB_LO, c);
		`CHK(c < 16'h1232 && c > 16'h1200, 1'b1)
		rd16(DWT_ADR_TB_LO, c);
		`CHK(c > 16'h1231, 1'b1)
		clr;
		set(1, 1'b0);
		cyc(6);
		`CHK(irq_req_q[6], 1'b0)
		wr(DWT_ADR_MODE_B, 8'h43);
		cyc(4);
		clr;
		set(1, 1'b1);
		cyc(6);
		`CHK(irq_req_q[6], 1'b1)
		wr(DWT_ADR_MODE_B, 8'h00);
		wr16(DWT_ADR_TB_LO, 16'h0000);
		for (int i = 0; i < DWT_N8; i++)
			wr(DWT_ADR_T8_0 + 8'(i), 8'h00);
		wr(DWT_ADR_MODE_A, 8'h00);
		wr16(DWT_ADR_TA_LO, 16'h0000);
		wr(DWT_ADR_MODE_8, 8'h80);
		cyc(20);
		clr;
		cyc(100);
		`CHK(irq_req_q, 8'h00)
		sub_en <= 1'b1;
		wait_chg(0, 300, n);
		`CHK(n < 80, 1'b1)
		cyc(100);
		`CHK(irq_req_q[4:0], 5'h1f)
		close_out;
	end
endmodule
`undef CHK
`default_nettype wire

// ===== logic/dwt_pin_sync.sv
/*
 Two-stage synchroniser with edge detection for one external pin.
 Assumes the pin is asynchronous to clk and rst_n is already synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module dwt_pin_sync
(
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Raw pin.
	input  wire logic             pin,
	// Synchronised level and one-cycle edge pulses.
	output dwt_pkg::dwt_pin_t     ev
);
	import dwt_pkg::*;

	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end
		else
		begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign ev.level = s2_q;
	assign ev.rise  = s2_q & ~s3_q;
	assign ev.fall  = ~s2_q & s3_q;

endmodule
`default_nettype wire

// ===== logic/dwt_pkg.sv
/*
 Constants, field positions and carrier types for the dual wide timer unit.
 Assumes a byte-wide register port and a single system clock.
*/
`default_nettype none
package dwt_pkg;

	// Register addresses, one byte each.
	localparam logic [7:0] DWT_ADR_TA_LO  = 8'h20;
	localparam logic [7:0] DWT_ADR_TA_HI  = 8'h21;
	localparam logic [7:0] DWT_ADR_TB_LO  = 8'h22;
	localparam logic [7:0] DWT_ADR_TB_HI  = 8'h23;
	localparam logic [7:0] DWT_ADR_T8_0   = 8'h24;
	localparam logic [7:0] DWT_ADR_MODE_A = 8'h27;
	localparam logic [7:0] DWT_ADR_MODE_B = 8'h28;
	localparam logic [7:0] DWT_ADR_MODE_8 = 8'h29;
	localparam logic [7:0] DWT_ADR_IRQ    = 8'h2e;

	// Mode register A fields.
	localparam int DWT_MA_WCTL = 2;
	localparam int DWT_MA_RTEN = 3;
	localparam int DWT_MA_RT0  = 4;
	localparam int DWT_MA_RT1  = 5;
	// Edge select and stop share positions in modes A and B.
	localparam int DWT_M_EDGE  = 6;
	localparam int DWT_M_STOP  = 7;
	// Mode register for the 8-bit timers.
	localparam int DWT_M8_T2WC  = 0;
	localparam int DWT_M8_STOP0 = 1;
	localparam int DWT_M8_LOWSP = 7;

	// Interrupt request bit positions.
	localparam int DWT_IRQ_TA = 0;
	localparam int DWT_IRQ_TB = 1;
	localparam int DWT_IRQ_T8 = 2;
	localparam int DWT_IRQ_PA = 5;
	localparam int DWT_IRQ_PB = 6;
	localparam int DWT_IRQ_W  = 7;

	localparam int DWT_N8 = 3;

	// Divide by 16 for the count source.
	localparam logic [3:0]  DWT_PRE_LAST = 4'hf;
	localparam logic [15:0] DWT_T16_RST  = 16'hffff;
	localparam logic [7:0]  DWT_T8_RST   = 8'hff;
	localparam logic [7:0]  DWT_REG_RST  = 8'h00;

	typedef enum logic [1:0] {
		DWT_MODE_TIMER,
		DWT_MODE_ALT,
		DWT_MODE_EVENT,
		DWT_MODE_WIDTH
	} dwt_mode_t;

	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} dwt_pin_t;

endpackage
`default_nettype wire

// ===== logic/dwt_timer_unit.sv
/*
 Timer unit: two 16-bit and three 8-bit down counters with byte access.
 Assumes clk is the main oscillator and software keeps the byte order.
*/
// Notes on behaviour
// - Two 16-bit timers and three 8-bit timers are provided.
// - Counters count down; a pulse at zero reloads from the latch.
// - Every underflow sets that timer's interrupt request bit.
// - Timer A counts the clock over 16, or sub-oscillator over 16.
// - Pulse output mode toggles pin A on each underflow.
// - Event mode on timer A counts edges at pin A.
// - Width mode counts while pin A is high, or low if edge bit set.
// - Write control clear: write loads counter and latch together.
// - Write control set: write loads latch only, counter at underflow.
// - Pin A interrupt edge follows the edge select bit.
// - Real time data go to the pins at each timer A underflow.
// - Enabling the real time port drives data out at once.
// - Changed real time data wait for the next underflow.
// - Timer B has four modes; timer mode counts the clock or sub-oscillator over 16.
// - Period mode: selected pin B edge raises request and reloads.
// - Value before an edge reload is held until timer B is read.
// - Event mode on timer B counts edges at pin B.
// - Width mode on timer B requests on both edges.
`timescale 1ns/100ps
`default_nettype none
module dwt_timer_unit
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        nrst,
	// Register port.
	input  wire logic [7:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_q,
	// External count pins and sub-oscillator.
	input  wire logic        ext_count_pin_a_i,
	output logic             ext_count_pin_a_o,
	output logic             ext_count_pin_a_oe,
	input  wire logic        ext_count_pin_b_i,
	input  wire logic        sub_osc_in,
	// Real time port pins.
	output logic             rt_out_pin0,
	output logic             rt_out_pin1,
	// Interrupt request bits.
	output logic      [7:0]  irq_req_q
);
	import dwt_pkg::*;

	logic rst_s1_q;
	logic rst_n_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	dwt_pin_t pa;
	dwt_pin_t pb;
	dwt_pin_t ps;

	dwt_pin_sync u_sync_a (.clk(clk), .rst_n(rst_n_q),
		.pin(ext_count_pin_a_i), .ev(pa));
	dwt_pin_sync u_sync_b (.clk(clk), .rst_n(rst_n_q),
		.pin(ext_count_pin_b_i), .ev(pb));
	dwt_pin_sync u_sync_s (.clk(clk), .rst_n(rst_n_q),
		.pin(sub_osc_in), .ev(ps));

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	logic [7:0]  mode_a_q;
	logic [7:0]  mode_b_q;
	logic [7:0]  mode_8_q;
	dwt_mode_t   ma;
	dwt_mode_t   mb;
	logic        wr_ta_hi;
	logic        wr_tb_hi;
	logic        rd_tb_lo;

	assign ma       = dwt_mode_t'(mode_a_q[1:0]);
	assign mb       = dwt_mode_t'(mode_b_q[1:0]);
	assign wr_ta_hi = wr_i && hit(addr_i, DWT_ADR_TA_HI);
	assign wr_tb_hi = wr_i && hit(addr_i, DWT_ADR_TB_HI);
	assign rd_tb_lo = rd_i && hit(addr_i, DWT_ADR_TB_LO);

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			mode_a_q <= DWT_REG_RST;
			mode_b_q <= DWT_REG_RST;
			mode_8_q <= DWT_REG_RST;
		end
		else if (wr_i)
		begin
			if (hit(addr_i, DWT_ADR_MODE_A))
				mode_a_q <= wdata_i;
			if (hit(addr_i, DWT_ADR_MODE_B))
				mode_b_q <= wdata_i;
			if (hit(addr_i, DWT_ADR_MODE_8))
				mode_8_q <= wdata_i;
		end
	end

	// Divided count source: clk over 16, or sub-oscillator edges over 16.
	logic [3:0] pre_q;
	logic       tick_q;
	logic       pre_step;

	assign pre_step = mode_8_q[DWT_M8_LOWSP] ? ps.rise : 1'b1;

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			pre_q  <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			if (pre_step)
				pre_q <= pre_q + 4'h1;
			tick_q <= pre_step && (pre_q == DWT_PRE_LAST);
		end
	end

	// Byte buffers; correct only while software keeps the byte order.
	logic [7:0] wbuf_q;
	logic [7:0] rbuf_q;

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			wbuf_q <= DWT_REG_RST;
		else if (wr_i && (hit(addr_i, DWT_ADR_TA_LO) ||
			hit(addr_i, DWT_ADR_TB_LO)))
			wbuf_q <= wdata_i;
	end

	// Timer A.
	logic [15:0] ta_cnt_q;
	logic [15:0] ta_lat_q;
	logic        ta_en;
	logic        ta_uf;
	logic        pa_act;

	assign pa_act = mode_a_q[DWT_M_EDGE] ? pa.fall : pa.rise;

	always_comb
	begin
		case (ma)
			DWT_MODE_TIMER: ta_en = tick_q;
			DWT_MODE_ALT:   ta_en = tick_q;
			DWT_MODE_EVENT: ta_en = pa_act;
			DWT_MODE_WIDTH: ta_en = tick_q &&
				(pa.level != mode_a_q[DWT_M_EDGE]);
			default:        ta_en = 1'b0;
		endcase
		if (mode_a_q[DWT_M_STOP])
			ta_en = 1'b0;
	end

	assign ta_uf = ta_en && (ta_cnt_q == '0);

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ta_cnt_q <= DWT_T16_RST;
			ta_lat_q <= DWT_T16_RST;
		end
		else
		begin
			if (wr_ta_hi)
				ta_lat_q <= {wdata_i, wbuf_q};
			if (wr_ta_hi && !mode_a_q[DWT_MA_WCTL])
				ta_cnt_q <= {wdata_i, wbuf_q};
			else if (ta_uf)
				ta_cnt_q <= ta_lat_q;
			else if (ta_en)
				ta_cnt_q <= ta_cnt_q - 16'h0001;
		end
	end

	// Pin A drive and real time port.
	logic rt_en_prev_q;
	logic rt_rise;

	assign rt_rise = mode_a_q[DWT_MA_RTEN] && !rt_en_prev_q;

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ext_count_pin_a_o  <= 1'b0;
			ext_count_pin_a_oe <= 1'b0;
		end
		else
		begin
			ext_count_pin_a_oe <= (ma == DWT_MODE_ALT);
			if (ta_uf && ma == DWT_MODE_ALT)
				ext_count_pin_a_o <= ~ext_count_pin_a_o;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			rt_en_prev_q <= 1'b0;
			rt_out_pin0  <= 1'b0;
			rt_out_pin1  <= 1'b0;
		end
		else
		begin
			rt_en_prev_q <= mode_a_q[DWT_MA_RTEN];
			if (rt_rise || (mode_a_q[DWT_MA_RTEN] && ta_uf))
			begin
				rt_out_pin0 <= mode_a_q[DWT_MA_RT0];
				rt_out_pin1 <= mode_a_q[DWT_MA_RT1];
			end
		end
	end

	// Timer B.
	logic [15:0] tb_cnt_q;
	logic [15:0] tb_lat_q;
	logic [15:0] tb_cap_q;
	logic        tb_cap_v_q;
	logic        tb_en;
	logic        tb_uf;
	logic        pb_act;
	logic        pb_irq;
	logic        tb_edge_ld;

	assign pb_act = mode_b_q[DWT_M_EDGE] ? pb.fall : pb.rise;
	assign pb_irq = (mb == DWT_MODE_WIDTH) ? (pb.rise || pb.fall)
		: pb_act;
	assign tb_edge_ld = pb_irq &&
		(mb == DWT_MODE_ALT || mb == DWT_MODE_WIDTH);

	always_comb
	begin
		case (mb)
			DWT_MODE_EVENT: tb_en = pb_act;
			default:        tb_en = tick_q;
		endcase
		if (mode_b_q[DWT_M_STOP])
			tb_en = 1'b0;
	end

	assign tb_uf = tb_en && (tb_cnt_q == '0) && !tb_edge_ld;

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			tb_cnt_q <= DWT_T16_RST;
			tb_lat_q <= DWT_T16_RST;
		end
		else
		begin
			if (wr_tb_hi)
				tb_lat_q <= {wdata_i, wbuf_q};
			if (wr_tb_hi)
				tb_cnt_q <= {wdata_i, wbuf_q};
			else if (tb_edge_ld || tb_uf)
				tb_cnt_q <= tb_lat_q;
			else if (tb_en)
				tb_cnt_q <= tb_cnt_q - 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			tb_cap_q   <= DWT_T16_RST;
			tb_cap_v_q <= 1'b0;
		end
		else if (tb_edge_ld && !wr_tb_hi)
		begin
			tb_cap_q   <= tb_cnt_q;
			tb_cap_v_q <= 1'b1;
		end
		else if (rd_tb_lo)
			tb_cap_v_q <= 1'b0;
	end

	// Three 8-bit timers.
	logic [7:0] t8_val [DWT_N8];
	logic       t8_uf  [DWT_N8];

	genvar gi;
	generate
		for (gi = 0; gi < DWT_N8; gi++)
		begin : g_t8
			logic [7:0] cnt_q;
			logic [7:0] lat_q;
			logic       en;
			logic       wr_me;
			logic       lat_only;

			assign en = tick_q && !mode_8_q[DWT_M8_STOP0 + gi];
			assign wr_me = wr_i &&
				hit(addr_i, DWT_ADR_T8_0 + 8'(gi));
			assign lat_only = (gi == 1) && mode_8_q[DWT_M8_T2WC];
			assign t8_uf[gi] = en && (cnt_q == '0);
			assign t8_val[gi] = cnt_q;

			always_ff @(posedge clk or negedge rst_n_q)
			begin
				if (!rst_n_q)
				begin
					cnt_q <= DWT_T8_RST;
					lat_q <= DWT_T8_RST;
				end
				else
				begin
					if (wr_me)
						lat_q <= wdata_i;
					if (wr_me && !lat_only)
						cnt_q <= wdata_i;
					else if (t8_uf[gi])
						cnt_q <= lat_q;
					else if (en)
						cnt_q <= cnt_q - 8'h01;
				end
			end
		end
	endgenerate

	// Request bits: write 0 clears, a new event in the same cycle wins.
	logic [7:0] irq_set;

	always_comb
	begin
		irq_set = '0;
		irq_set[DWT_IRQ_TA] = ta_uf;
		irq_set[DWT_IRQ_TB] = tb_uf;
		for (int i = 0; i < DWT_N8; i++)
			irq_set[DWT_IRQ_T8 + i] = t8_uf[i];
		irq_set[DWT_IRQ_PA] = pa_act;
		irq_set[DWT_IRQ_PB] = pb_irq;
	end

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			irq_req_q <= DWT_REG_RST;
		else if (wr_i && hit(addr_i, DWT_ADR_IRQ))
			irq_req_q <= (irq_req_q & wdata_i) | irq_set;
		else
			irq_req_q <= irq_req_q | irq_set;
	end

	// Read port; a high-byte read freezes the low byte for the next read.
	logic [15:0] tb_view;

	assign tb_view = tb_cap_v_q ? tb_cap_q : tb_cnt_q;

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			rdata_q <= DWT_REG_RST;
			rbuf_q  <= DWT_REG_RST;
		end
		else
		begin
			rdata_q <= DWT_REG_RST;
			if (rd_i)
			begin
				case (addr_i)
					DWT_ADR_TA_HI:
					begin
						rdata_q <= ta_cnt_q[15:8];
						rbuf_q  <= ta_cnt_q[7:0];
					end
					DWT_ADR_TB_HI:
					begin
						rdata_q <= tb_view[15:8];
						rbuf_q  <= tb_view[7:0];
					end
					DWT_ADR_TA_LO:  rdata_q <= rbuf_q;
					DWT_ADR_TB_LO:  rdata_q <= rbuf_q;
					DWT_ADR_T8_0:   rdata_q <= t8_val[0];
					DWT_ADR_T8_0 + 8'h01: rdata_q <= t8_val[1];
					DWT_ADR_T8_0 + 8'h02: rdata_q <= t8_val[2];
					DWT_ADR_MODE_A: rdata_q <= mode_a_q;
					DWT_ADR_MODE_B: rdata_q <= mode_b_q;
					DWT_ADR_MODE_8: rdata_q <= mode_8_q;
					DWT_ADR_IRQ:    rdata_q <= irq_req_q;
					default:        rdata_q <= DWT_REG_RST;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n_q);

	property p_ta_reload;
		ta_uf && !wr_ta_hi |=> ta_cnt_q == $past(ta_lat_q);
	endproperty
	a_ta_reload: assert property (p_ta_reload)
		else $error("timer A did not reload on underflow");

	property p_ta_irq;
		ta_uf |=> irq_req_q[DWT_IRQ_TA];
	endproperty
	a_ta_irq: assert property (p_ta_irq)
		else $error("timer A underflow did not raise its request");

	property p_pulse_toggle;
		ta_uf && ma == DWT_MODE_ALT
			|=> ext_count_pin_a_o != $past(ext_count_pin_a_o);
	endproperty
	a_pulse_toggle: assert property (p_pulse_toggle)
		else $error("pin A did not toggle on underflow");

	property p_wctl0;
		wr_ta_hi && !mode_a_q[DWT_MA_WCTL]
			|=> ta_cnt_q == ta_lat_q;
	endproperty
	a_wctl0: assert property (p_wctl0)
		else $error("write did not load counter and latch together");

	property p_wctl1;
		wr_ta_hi && mode_a_q[DWT_MA_WCTL] && !ta_en
			|=> ta_cnt_q == $past(ta_cnt_q);
	endproperty
	a_wctl1: assert property (p_wctl1)
		else $error("latch-only write changed the counter");

	property p_rt_enable;
		rt_rise |=> rt_out_pin0 == $past(mode_a_q[DWT_MA_RT0])
			&& rt_out_pin1 == $past(mode_a_q[DWT_MA_RT1]);
	endproperty
	a_rt_enable: assert property (p_rt_enable)
		else $error("real time data not driven on enable");

	property p_rt_hold;
		!rt_rise && !ta_uf |=> $stable(rt_out_pin0) && $stable(rt_out_pin1);
	endproperty
	a_rt_hold: assert property (p_rt_hold)
		else $error("real time pins changed without underflow");

	property p_pb_reload;
		tb_edge_ld && !wr_tb_hi
			|=> tb_cnt_q == $past(tb_lat_q) && tb_cap_v_q
			&& tb_cap_q == $past(tb_cnt_q);
	endproperty
	a_pb_reload: assert property (p_pb_reload)
		else $error("pin B edge did not reload and capture timer B");

	property p_width_edges;
		mb == DWT_MODE_WIDTH && (pb.rise || pb.fall)
			|=> irq_req_q[DWT_IRQ_PB];
	endproperty
	a_width_edges: assert property (p_width_edges)
		else $error("width mode edge did not raise pin B request");

	c_ta_uf: cover property (ta_uf ##1 irq_req_q[DWT_IRQ_TA]);
	c_pb_ld: cover property (tb_edge_ld ##[1:20] rd_tb_lo);
	c_rt_on: cover property (rt_rise ##[1:100] ta_uf);

endmodule
`default_nettype wire
